//--- include/mise_pkg.sv
// Purpose: shared constants and types for the instruction execute block
// Assumes: 8-bit data path, 12-bit program counter, 15-bit program word
// Notes: opcode codes are the decoder's own encoding, not the opcode bits
package mise_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int PC_W = 12;
	localparam int ROM_W = 15;
	localparam int PAGE_W = 4;
	localparam int HIGH_W = 7;
	localparam int BIT_W = 3;
	localparam int STACK_DEPTH = 6;
	localparam int SP_W = 3;
	// Data memory address at which the program counter low byte is mapped
	localparam logic [7:0] PC_LOW_ADDR = 8'h06;
	localparam logic [3:0] LAST_PAGE = 4'hf;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] BYTE_ONES = 8'hff;
	localparam logic [11:0] PC_ONE = 12'h001;
	localparam logic [11:0] PC_TWO = 12'h002;
	localparam logic [11:0] PC_RESET = 12'h000;
	localparam logic [2:0] SP_ONE = 3'h1;

	typedef enum logic [5:0] {
		OP_NOP = 6'h00, OP_ROT_R = 6'h01, OP_ROT_R_ACC = 6'h02,
		OP_ROT_L = 6'h03, OP_ROT_L_ACC = 6'h04,
		OP_ROT_R_CARRY = 6'h05, OP_ROT_R_CARRY_ACC = 6'h06,
		OP_ROT_L_CARRY = 6'h07, OP_ROT_L_CARRY_ACC = 6'h08,
		OP_MOVE_M_TO_ACC = 6'h09, OP_MOVE_ACC_TO_M = 6'h0a,
		OP_MOVE_IMM = 6'h0b, OP_BIT_CLEAR = 6'h0c, OP_BIT_SET = 6'h0d,
		OP_JUMP = 6'h0e, OP_SKIP_ZERO = 6'h0f,
		OP_SKIP_ZERO_WITH_MOVE = 6'h10, OP_SKIP_BIT_ZERO = 6'h11,
		OP_SKIP_BIT_ONE = 6'h12, OP_INC_SKIP = 6'h13, OP_DEC_SKIP = 6'h14,
		OP_INC_SKIP_ACC = 6'h15, OP_DEC_SKIP_ACC = 6'h16, OP_CALL = 6'h17,
		OP_RETURN = 6'h18, OP_RETURN_IMM = 6'h19, OP_RETURN_INT = 6'h1a,
		OP_TABLE_CURRENT = 6'h1b, OP_TABLE_LAST = 6'h1c,
		OP_BYTE_CLEAR = 6'h1d, OP_BYTE_SET = 6'h1e, OP_WATCHDOG_CLEAR = 6'h1f,
		OP_PRECLEAR_FIRST = 6'h20, OP_PRECLEAR_SECOND = 6'h21,
		OP_SWAP = 6'h22, OP_SWAP_ACC = 6'h23, OP_HALT = 6'h24
	} mise_op_type;

	typedef enum logic [2:0] {
		ST_EXEC = 3'b001,
		ST_SECOND = 3'b010,
		ST_TABLE = 3'b100
	} mise_state_type;
endpackage

//--- logic/mise_core.sv
// Purpose: execute rotate, move, bit, branch, skip, table and misc ops
// Assumes: decoded op arrives with the addressed byte on mem_rdata
// Notes: two-cycle ops hold instr_ready low for one extra cycle
`timescale 1ns/100ps
module mise_core (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic instr_valid,
	input wire mise_pkg::mise_op_type instr_op,
	input wire logic [7:0] instr_addr,
	input wire logic [2:0] instr_bit,
	input wire logic [7:0] instr_imm,
	input wire logic [11:0] instr_target,
	input wire logic [7:0] mem_rdata,
	input wire logic [14:0] rom_data,
	input wire logic [7:0] table_pointer_low,
	input wire logic [7:0] table_pointer_high,
	input wire logic table_high_pointer_enable,
	input wire logic watchdog_timeout,
	input wire logic wake_up,
	output logic instr_ready,
	output logic [11:0] pc,
	output logic [7:0] acc,
	output logic carry,
	output logic mem_we,
	output logic [7:0] mem_waddr,
	output logic [7:0] mem_wdata,
	output logic rom_rd,
	output logic [11:0] rom_addr,
	output logic [6:0] table_result_high,
	output logic watchdog_timeout_flag,
	output logic powerdown_status_flag,
	output logic powerdown_mode,
	output logic watchdog_clear
);
	mise_pkg::mise_state_type state, next_state;
	logic [11:0] stack [mise_pkg::STACK_DEPTH];
	logic [2:0] sp;
	logic [7:0] table_dest;
	logic last_first, last_second;
	logic accept, fwd, pcl_hit, skip, two_cycle, table_op, halt;
	logic wd_full, wd_pair, pc_load, push, pop;
	logic [7:0] opnd, next_acc, wdata, one_hot_bit;
	logic next_carry, we;
	logic [11:0] next_pc, table_addr, pc_step;
	logic [2:0] sp_top;
	localparam logic [2:0] SP_LAST = 3'(mise_pkg::STACK_DEPTH - 1);

	assign accept = instr_valid & instr_ready;
	// A byte written last cycle is not yet in memory; forward it
	assign fwd = mem_we && (mem_waddr == instr_addr);
	assign opnd = fwd ? mem_wdata : mem_rdata;
	assign one_hot_bit = mise_pkg::BYTE_ONE << instr_bit;
	// Wrap inside the six entries so a deep nest never indexes past the array
	assign sp_top = (sp == 3'h0) ? SP_LAST : sp - mise_pkg::SP_ONE;
	assign table_addr = (instr_op == mise_pkg::OP_TABLE_LAST) ?
		{mise_pkg::LAST_PAGE, table_pointer_low} :
		table_high_pointer_enable ?
		{table_pointer_high[3:0], table_pointer_low} :
		{pc[11:8], table_pointer_low};
	assign table_op = (instr_op == mise_pkg::OP_TABLE_LAST) ||
		(instr_op == mise_pkg::OP_TABLE_CURRENT);
	assign pcl_hit = we && (instr_addr == mise_pkg::PC_LOW_ADDR);
	assign wd_pair = (instr_op == mise_pkg::OP_PRECLEAR_SECOND && last_first)
		|| (instr_op == mise_pkg::OP_PRECLEAR_FIRST && last_second);
	assign pc_step = skip ? mise_pkg::PC_TWO : mise_pkg::PC_ONE;
	assign next_pc = pcl_hit ? {pc[11:8], wdata} :
		pc_load ? instr_target :
		pop ? stack[sp_top] :
		pc + pc_step;

	always_comb begin
		next_acc = acc;
		next_carry = carry;
		we = 1'b0;
		wdata = opnd;
		skip = 1'b0;
		two_cycle = 1'b0;
		pc_load = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		halt = 1'b0;
		wd_full = 1'b0;
		unique case (instr_op)
			mise_pkg::OP_NOP: begin
				two_cycle = 1'b0;
			end
			mise_pkg::OP_ROT_R: begin
				we = 1'b1;
				wdata = {opnd[0], opnd[7:1]};
			end
			mise_pkg::OP_ROT_R_ACC: begin
				next_acc = {opnd[0], opnd[7:1]};
			end
			mise_pkg::OP_ROT_L: begin
				we = 1'b1;
				wdata = {opnd[6:0], opnd[7]};
			end
			mise_pkg::OP_ROT_L_ACC: begin
				next_acc = {opnd[6:0], opnd[7]};
			end
			mise_pkg::OP_ROT_R_CARRY: begin
				we = 1'b1;
				wdata = {carry, opnd[7:1]};
				next_carry = opnd[0];
			end
			mise_pkg::OP_ROT_R_CARRY_ACC: begin
				next_acc = {carry, opnd[7:1]};
				next_carry = opnd[0];
			end
			mise_pkg::OP_ROT_L_CARRY: begin
				we = 1'b1;
				wdata = {opnd[6:0], carry};
				next_carry = opnd[7];
			end
			mise_pkg::OP_ROT_L_CARRY_ACC: begin
				next_acc = {opnd[6:0], carry};
				next_carry = opnd[7];
			end
			mise_pkg::OP_MOVE_M_TO_ACC: begin
				next_acc = opnd;
			end
			mise_pkg::OP_MOVE_ACC_TO_M: begin
				we = 1'b1;
				wdata = acc;
			end
			mise_pkg::OP_MOVE_IMM: begin
				next_acc = instr_imm;
			end
			mise_pkg::OP_BIT_CLEAR: begin
				we = 1'b1;
				wdata = opnd & ~one_hot_bit;
			end
			mise_pkg::OP_BIT_SET: begin
				we = 1'b1;
				wdata = opnd | one_hot_bit;
			end
			mise_pkg::OP_JUMP: begin
				pc_load = 1'b1;
				two_cycle = 1'b1;
			end
			mise_pkg::OP_CALL: begin
				pc_load = 1'b1;
				push = 1'b1;
				two_cycle = 1'b1;
			end
			mise_pkg::OP_RETURN, mise_pkg::OP_RETURN_INT: begin
				pop = 1'b1;
				two_cycle = 1'b1;
			end
			mise_pkg::OP_RETURN_IMM: begin
				pop = 1'b1;
				two_cycle = 1'b1;
				next_acc = instr_imm;
			end
			mise_pkg::OP_SKIP_ZERO: begin
				skip = (opnd == mise_pkg::BYTE_ZERO);
			end
			mise_pkg::OP_SKIP_ZERO_WITH_MOVE: begin
				next_acc = opnd;
				skip = (opnd == mise_pkg::BYTE_ZERO);
			end
			mise_pkg::OP_SKIP_BIT_ZERO: begin
				skip = ~|(opnd & one_hot_bit);
			end
			mise_pkg::OP_SKIP_BIT_ONE: begin
				skip = |(opnd & one_hot_bit);
			end
			mise_pkg::OP_INC_SKIP: begin
				we = 1'b1;
				wdata = opnd + mise_pkg::BYTE_ONE;
				skip = (opnd == mise_pkg::BYTE_ONES);
			end
			mise_pkg::OP_DEC_SKIP: begin
				we = 1'b1;
				wdata = opnd - mise_pkg::BYTE_ONE;
				skip = (opnd == mise_pkg::BYTE_ONE);
			end
			mise_pkg::OP_INC_SKIP_ACC: begin
				next_acc = opnd + mise_pkg::BYTE_ONE;
				skip = (opnd == mise_pkg::BYTE_ONES);
			end
			mise_pkg::OP_DEC_SKIP_ACC: begin
				next_acc = opnd - mise_pkg::BYTE_ONE;
				skip = (opnd == mise_pkg::BYTE_ONE);
			end
			mise_pkg::OP_TABLE_CURRENT, mise_pkg::OP_TABLE_LAST: begin
				two_cycle = 1'b0;
			end
			mise_pkg::OP_BYTE_CLEAR: begin
				we = 1'b1;
				wdata = mise_pkg::BYTE_ZERO;
			end
			mise_pkg::OP_BYTE_SET: begin
				we = 1'b1;
				wdata = mise_pkg::BYTE_ONES;
			end
			mise_pkg::OP_WATCHDOG_CLEAR: begin
				wd_full = 1'b1;
			end
			mise_pkg::OP_PRECLEAR_FIRST, mise_pkg::OP_PRECLEAR_SECOND: begin
				wd_full = wd_pair;
			end
			mise_pkg::OP_SWAP: begin
				we = 1'b1;
				wdata = {opnd[3:0], opnd[7:4]};
			end
			mise_pkg::OP_SWAP_ACC: begin
				next_acc = {opnd[3:0], opnd[7:4]};
			end
			mise_pkg::OP_HALT: begin
				halt = 1'b1;
			end
			default: begin
				two_cycle = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_state = state;
		unique case (state)
			mise_pkg::ST_EXEC: begin
				if (accept && table_op) begin
					next_state = mise_pkg::ST_TABLE;
				end else if (accept && (two_cycle || skip || pcl_hit)) begin
					next_state = mise_pkg::ST_SECOND;
				end
			end
			mise_pkg::ST_SECOND: begin
				next_state = mise_pkg::ST_EXEC;
			end
			mise_pkg::ST_TABLE: begin
				next_state = mise_pkg::ST_EXEC;
			end
			default: begin
				next_state = mise_pkg::ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= mise_pkg::ST_EXEC;
			instr_ready <= 1'b0;
			powerdown_mode <= 1'b0;
		end else begin
			state <= next_state;
			if (accept && halt) begin
				powerdown_mode <= 1'b1;
			end else if (wake_up) begin
				powerdown_mode <= 1'b0;
			end
			// Power down holds ready low until a wake-up arrives
			instr_ready <= (next_state == mise_pkg::ST_EXEC) &&
				!(accept && halt) && (!powerdown_mode || wake_up);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pc <= mise_pkg::PC_RESET;
			acc <= mise_pkg::BYTE_ZERO;
			carry <= 1'b0;
			sp <= '0;
		end else if (accept) begin
			pc <= next_pc;
			acc <= next_acc;
			carry <= next_carry;
			if (push) begin
				sp <= (sp == SP_LAST) ? 3'h0 : sp + mise_pkg::SP_ONE;
			end else if (pop) begin
				sp <= sp_top;
			end
		end
	end

	// Stack wraps silently on overflow, as a six-deep return stack does
	always_ff @(posedge sys_clk) begin
		if (accept && push) begin
			stack[sp] <= pc + mise_pkg::PC_ONE;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_we <= 1'b0;
			mem_waddr <= mise_pkg::BYTE_ZERO;
			mem_wdata <= mise_pkg::BYTE_ZERO;
			rom_rd <= 1'b0;
			rom_addr <= mise_pkg::PC_RESET;
			table_dest <= mise_pkg::BYTE_ZERO;
			table_result_high <= '0;
		end else begin
			rom_rd <= accept && table_op;
			mem_we <= 1'b0;
			if (accept && table_op) begin
				rom_addr <= table_addr;
				table_dest <= instr_addr;
			end
			if (state == mise_pkg::ST_TABLE) begin
				mem_we <= 1'b1;
				mem_waddr <= table_dest;
				mem_wdata <= rom_data[7:0];
				table_result_high <= rom_data[14:8];
			end else if (accept && we) begin
				mem_we <= 1'b1;
				mem_waddr <= instr_addr;
				mem_wdata <= wdata;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			last_first <= 1'b0;
			last_second <= 1'b0;
			watchdog_timeout_flag <= 1'b0;
			powerdown_status_flag <= 1'b0;
			watchdog_clear <= 1'b0;
		end else begin
			watchdog_clear <= accept && (wd_full || halt);
			if (accept) begin
				last_first <= instr_op == mise_pkg::OP_PRECLEAR_FIRST && !wd_pair;
				last_second <= instr_op == mise_pkg::OP_PRECLEAR_SECOND &&
					!wd_pair;
			end
			// A timeout in the clearing cycle is kept: set beats clear
			if (watchdog_timeout) begin
				watchdog_timeout_flag <= 1'b1;
			end else if (accept && (wd_full || halt)) begin
				watchdog_timeout_flag <= 1'b0;
			end
			if (accept && halt) begin
				powerdown_status_flag <= 1'b1;
			end else if (accept && wd_full) begin
				powerdown_status_flag <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	AST_ROT_KEEPS_CARRY: assert property (
		accept && instr_op == mise_pkg::OP_ROT_R &&
		instr_addr != mise_pkg::PC_LOW_ADDR |=>
		carry == $past(carry) && mem_we && instr_ready)
		else $error("plain rotate changed carry or took two cycles");
	AST_RIGHT_CARRY: assert property (
		accept && instr_op == mise_pkg::OP_ROT_R_CARRY |=>
		carry == $past(opnd[0]) && mem_wdata[7] == $past(carry))
		else $error("right rotate through carry wrong");
	AST_LEFT_CARRY: assert property (
		accept && instr_op == mise_pkg::OP_ROT_L_CARRY_ACC |=>
		carry == $past(opnd[7]) && acc[0] == $past(carry) && !mem_we)
		else $error("left rotate through carry wrong");
	AST_MOVE_TO_MEM: assert property (
		accept && instr_op == mise_pkg::OP_MOVE_ACC_TO_M |=>
		mem_we && mem_wdata == $past(acc) && carry == $past(carry))
		else $error("move to memory wrong");
	AST_BIT_SET: assert property (
		accept && instr_op == mise_pkg::OP_BIT_SET |=>
		mem_wdata == ($past(opnd) | (8'h01 << $past(instr_bit))))
		else $error("bit set touched other bits");
	AST_SKIP_TWO: assert property (
		accept && skip && !powerdown_mode |=> !instr_ready ##1 instr_ready)
		else $error("taken skip did not cost exactly two cycles");
	AST_JUMP_TWO: assert property (
		accept && instr_op == mise_pkg::OP_JUMP |=>
		pc == $past(instr_target) && !instr_ready)
		else $error("jump wrong target or timing");
	AST_TABLE_LAST: assert property (
		accept && instr_op == mise_pkg::OP_TABLE_LAST |=>
		rom_rd && rom_addr[11:8] == mise_pkg::LAST_PAGE && !instr_ready
		##1 mem_we && mem_wdata == $past(rom_data[7:0]))
		else $error("last page table read wrong");
	AST_PAIR_NEEDED: assert property (
		accept && instr_op == mise_pkg::OP_PRECLEAR_SECOND && !last_first
		&& !watchdog_timeout |=>
		$stable(watchdog_timeout_flag) && $stable(powerdown_status_flag))
		else $error("lone pre-clear changed watchdog flags");
	AST_HALT_ENTRY: assert property (
		accept && instr_op == mise_pkg::OP_HALT |=>
		powerdown_mode && powerdown_status_flag && !instr_ready)
		else $error("halt did not enter power down");

	COV_SKIP: cover property (accept && skip);
	COV_TABLE: cover property (accept && table_op ##2 instr_ready);
	COV_PAIR: cover property (accept && wd_pair);
	COV_PCL: cover property (accept && pcl_hit);
endmodule

//--- tb/mise_core_tb.sv
// Purpose: self-checking bench for the instruction execute block
// Assumes: bench plays data memory and program memory for the core
// Notes: expected memory writes queue up; a monitor pops and compares them
`timescale 1ns/100ps
module mise_core_tb;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic instr_valid = 1'b0;
	mise_pkg::mise_op_type instr_op = mise_pkg::OP_NOP;
	logic [7:0] instr_addr = 8'h00;
	logic [2:0] instr_bit = 3'h0;
	logic [7:0] instr_imm = 8'h00;
	logic [11:0] instr_target = 12'h000;
	logic [7:0] mem_rdata;
	logic [14:0] rom_data;
	logic [7:0] table_pointer_low = 8'h00;
	logic [7:0] table_pointer_high = 8'h00;
	logic table_high_pointer_enable = 1'b0;
	logic watchdog_timeout = 1'b0;
	logic wake_up = 1'b0;
	logic instr_ready, carry, mem_we, rom_rd, watchdog_clear;
	logic watchdog_timeout_flag, powerdown_status_flag, powerdown_mode;
	logic [11:0] pc, rom_addr;
	logic [7:0] acc, mem_waddr, mem_wdata;
	logic [6:0] table_result_high;
	logic [7:0] ram [256];
	logic [7:0] mdl [256];
	logic [7:0] e_acc;
	logic [11:0] e_pc;
	logic [6:0] e_th;
	logic e_c, e_to, e_pd;
	logic [11:0] stk [$];
	logic [15:0] wq [$];
	mise_pkg::mise_op_type last;
	mise_pkg::mise_op_type ops [$];
	int num_errors = 0;
	int checked = 0;

	always #5 sys_clk = ~sys_clk;

	function automatic logic [14:0] rom_of(input logic [11:0] r);
		return {r[6:0], ~r[7:0]};
	endfunction

	assign mem_rdata = ram[instr_addr];
	assign rom_data = rom_of(rom_addr);

	mise_core i_dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .instr_valid(instr_valid),
		.instr_op(instr_op), .instr_addr(instr_addr), .instr_bit(instr_bit),
		.instr_imm(instr_imm), .instr_target(instr_target),
		.mem_rdata(mem_rdata), .rom_data(rom_data),
		.table_pointer_low(table_pointer_low),
		.table_pointer_high(table_pointer_high),
		.table_high_pointer_enable(table_high_pointer_enable),
		.watchdog_timeout(watchdog_timeout), .wake_up(wake_up),
		.instr_ready(instr_ready), .pc(pc), .acc(acc), .carry(carry),
		.mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
		.rom_rd(rom_rd), .rom_addr(rom_addr),
		.table_result_high(table_result_high),
		.watchdog_timeout_flag(watchdog_timeout_flag),
		.powerdown_status_flag(powerdown_status_flag),
		.powerdown_mode(powerdown_mode), .watchdog_clear(watchdog_clear)
	);

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Writes to the counter low byte go to the program counter, not memory
	always @(posedge sys_clk) begin
		if (rst_b === 1'b1 && mem_we === 1'b1 &&
			mem_waddr !== mise_pkg::PC_LOW_ADDR) begin
			ram[mem_waddr] <= mem_wdata;
			if (wq.size() == 0)
				chk({mem_waddr, mem_wdata}, 16'hxxxx); // no stray write
			else
				chk({mem_waddr, mem_wdata}, wq.pop_front()); // write data
		end
	end

	task automatic idle(input int n);
		@(negedge sys_clk);
		instr_valid = 1'b0;
		repeat (n - 1) @(negedge sys_clk);
	endtask

	task automatic issue(input mise_pkg::mise_op_type op, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] x, input logic [11:0] t);
		logic [7:0] m;
		logic [7:0] w;
		logic [11:0] ra;
		logic [14:0] rw;
		logic wr, sk, two, trd, clr;
		logic [3:0] pg;
		int n;
		m = mdl[a];
		ra = {e_pc[11:8], table_pointer_low};
		if (table_high_pointer_enable)
			ra = {table_pointer_high[3:0], table_pointer_low};
		if (op == mise_pkg::OP_TABLE_LAST)
			ra = {mise_pkg::LAST_PAGE, table_pointer_low};
		rw = rom_of(ra);
		trd = op inside {mise_pkg::OP_TABLE_CURRENT, mise_pkg::OP_TABLE_LAST};
		clr = 1'b0;
		case (op)
			mise_pkg::OP_ROT_R, mise_pkg::OP_ROT_R_ACC: w = {m[0], m[7:1]};
			mise_pkg::OP_ROT_L, mise_pkg::OP_ROT_L_ACC: w = {m[6:0], m[7]};
			mise_pkg::OP_ROT_R_CARRY,
			mise_pkg::OP_ROT_R_CARRY_ACC: w = {e_c, m[7:1]};
			mise_pkg::OP_ROT_L_CARRY,
			mise_pkg::OP_ROT_L_CARRY_ACC: w = {m[6:0], e_c};
			mise_pkg::OP_MOVE_ACC_TO_M: w = e_acc;
			mise_pkg::OP_MOVE_IMM, mise_pkg::OP_RETURN_IMM: w = x;
			mise_pkg::OP_BIT_CLEAR: w = m & ~(8'h01 << b);
			mise_pkg::OP_BIT_SET: w = m | (8'h01 << b);
			mise_pkg::OP_INC_SKIP, mise_pkg::OP_INC_SKIP_ACC: w = m + 8'h01;
			mise_pkg::OP_DEC_SKIP, mise_pkg::OP_DEC_SKIP_ACC: w = m - 8'h01;
			mise_pkg::OP_BYTE_CLEAR: w = 8'h00;
			mise_pkg::OP_BYTE_SET: w = 8'hff;
			mise_pkg::OP_SWAP, mise_pkg::OP_SWAP_ACC: w = {m[3:0], m[7:4]};
			default: w = m;
		endcase
		case (op)
			mise_pkg::OP_SKIP_ZERO,
			mise_pkg::OP_SKIP_ZERO_WITH_MOVE: sk = (m == 8'h00);
			mise_pkg::OP_SKIP_BIT_ZERO: sk = !m[b];
			mise_pkg::OP_SKIP_BIT_ONE: sk = m[b];
			mise_pkg::OP_INC_SKIP, mise_pkg::OP_DEC_SKIP,
			mise_pkg::OP_INC_SKIP_ACC,
			mise_pkg::OP_DEC_SKIP_ACC: sk = (w == 8'h00);
			default: sk = 1'b0;
		endcase
		if (op inside {mise_pkg::OP_ROT_R_CARRY, mise_pkg::OP_ROT_R_CARRY_ACC})
			e_c = m[0];
		if (op inside {mise_pkg::OP_ROT_L_CARRY, mise_pkg::OP_ROT_L_CARRY_ACC})
			e_c = m[7];
		if (op inside {mise_pkg::OP_ROT_R_ACC, mise_pkg::OP_ROT_L_ACC,
			mise_pkg::OP_ROT_R_CARRY_ACC, mise_pkg::OP_ROT_L_CARRY_ACC,
			mise_pkg::OP_MOVE_M_TO_ACC, mise_pkg::OP_MOVE_IMM,
			mise_pkg::OP_SKIP_ZERO_WITH_MOVE, mise_pkg::OP_INC_SKIP_ACC,
			mise_pkg::OP_DEC_SKIP_ACC, mise_pkg::OP_RETURN_IMM,
			mise_pkg::OP_SWAP_ACC})
			e_acc = w;
		wr = op inside {mise_pkg::OP_ROT_R, mise_pkg::OP_ROT_L,
			mise_pkg::OP_ROT_R_CARRY, mise_pkg::OP_ROT_L_CARRY,
			mise_pkg::OP_MOVE_ACC_TO_M, mise_pkg::OP_BIT_CLEAR,
			mise_pkg::OP_BIT_SET, mise_pkg::OP_INC_SKIP, mise_pkg::OP_DEC_SKIP,
			mise_pkg::OP_BYTE_CLEAR, mise_pkg::OP_BYTE_SET, mise_pkg::OP_SWAP};
		two = sk | trd | (op inside {mise_pkg::OP_JUMP, mise_pkg::OP_CALL,
			mise_pkg::OP_RETURN, mise_pkg::OP_RETURN_IMM,
			mise_pkg::OP_RETURN_INT, mise_pkg::OP_HALT});
		// A low byte write keeps the page of the writing instruction
		pg = e_pc[11:8];
		e_pc = e_pc + (sk ? mise_pkg::PC_TWO : mise_pkg::PC_ONE);
		if (op == mise_pkg::OP_CALL)
			stk.push_back(e_pc);
		if (op == mise_pkg::OP_JUMP || op == mise_pkg::OP_CALL)
			e_pc = t;
		if (op inside {mise_pkg::OP_RETURN, mise_pkg::OP_RETURN_IMM,
			mise_pkg::OP_RETURN_INT})
			e_pc = stk.pop_back();
		if (wr && a == mise_pkg::PC_LOW_ADDR) begin
			e_pc = {pg, w};
			two = 1'b1;
		end else if (wr) begin
			mdl[a] = w;
			wq.push_back({a, w});
		end
		if (trd) begin
			mdl[a] = rw[7:0];
			wq.push_back({a, rw[7:0]});
			e_th = rw[14:8];
		end
		if (op == mise_pkg::OP_WATCHDOG_CLEAR || op == mise_pkg::OP_HALT ||
			(op == mise_pkg::OP_PRECLEAR_FIRST &&
			last == mise_pkg::OP_PRECLEAR_SECOND) ||
			(op == mise_pkg::OP_PRECLEAR_SECOND &&
			last == mise_pkg::OP_PRECLEAR_FIRST)) begin
			e_to = 1'b0;
			e_pd = (op == mise_pkg::OP_HALT);
			clr = 1'b1;
		end
		last = op;
		@(negedge sys_clk);
		instr_valid = 1'b1;
		instr_op = op;
		instr_addr = a;
		instr_bit = b;
		instr_imm = x;
		instr_target = t;
		n = 0;
		while (instr_ready !== 1'b1) begin
			@(negedge sys_clk);
			n++;
			if (n > 40) begin
				chk(16'h0000, 16'h0001); // ready wait ran out
				complete_run();
			end
		end
		@(posedge sys_clk);
		#1;
		chk(pc, e_pc); // counter flow
		chk(acc, e_acc); // accumulator
		chk(carry, e_c); // carry
		chk(instr_ready, !two); // cycle count
		chk(watchdog_timeout_flag, e_to); // timeout
		chk(powerdown_status_flag, e_pd); // power
		if (trd)
			chk({rom_rd, 3'h0, rom_addr}, {4'h8, ra});
		chk(watchdog_clear, clr); // counter clear
	endtask

	initial begin
		e_acc = 8'h00;
		e_pc = 12'h000;
		e_c = 1'b0;
		e_to = 1'b0;
		e_pd = 1'b0;
		e_th = 7'h00;
		last = mise_pkg::OP_NOP;
		void'($urandom(51664));
		for (int i = 0; i < 256; i++) begin
			ram[i] = 8'($urandom);
			mdl[i] = ram[i];
		end
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_b = 1'b1;
		chk({pc, acc[3:0]}, 16'h0000); // cleared state
		$display("test reset done");
		for (int c = 0; c <= 'h16; c++)
			ops.push_back(mise_pkg::mise_op_type'(c));
		ops.push_back(mise_pkg::OP_BYTE_CLEAR);
		ops.push_back(mise_pkg::OP_BYTE_SET);
		ops.push_back(mise_pkg::OP_SWAP);
		ops.push_back(mise_pkg::OP_SWAP_ACC);
		// Boundary bytes make all but the decrement skips and zero results land both ways
		for (int p = 0; p < 4; p++) begin
			foreach (ops[k]) begin
				ram[8'h20 + 8'(p * 28 + k)] = ($urandom % 2) ? 8'($urandom) :
					(($urandom % 2) ? 8'h00 : 8'hff);
				mdl[8'h20 + 8'(p * 28 + k)] = ram[8'h20 + 8'(p * 28 + k)];
				issue(ops[k], 8'h20 + 8'(p * 28 + k), 3'($urandom),
					8'($urandom), 12'($urandom));
			end
		end
		issue(mise_pkg::OP_MOVE_ACC_TO_M, mise_pkg::PC_LOW_ADDR, 3'h0,
			8'h00, 12'h000);
		issue(mise_pkg::OP_NOP, 8'h00, 3'h0, 8'h00, 12'h000);
		$display("test ops done");
		for (int k = 0; k < 3; k++)
			issue(mise_pkg::OP_CALL, 8'h00, 3'h0, 8'h00, 12'($urandom));
		issue(mise_pkg::OP_RETURN, 8'h00, 3'h0, 8'h00, 12'h000);
		issue(mise_pkg::OP_RETURN_IMM, 8'h00, 3'h0, 8'h5a, 12'h000);
		issue(mise_pkg::OP_RETURN_INT, 8'h00, 3'h0, 8'h00, 12'h000);
		$display("test calls done");
		for (int k = 0; k < 3; k++) begin
			idle(1);
			table_high_pointer_enable = (k == 0);
			table_pointer_low = 8'($urandom);
			table_pointer_high = 8'($urandom);
			issue(k == 2 ? mise_pkg::OP_TABLE_LAST : mise_pkg::OP_TABLE_CURRENT,
				8'hc0 + 8'(k), 3'h0, 8'h00, 12'h000);
			idle(3);
			chk(table_result_high, e_th);
		end
		$display("test tables done");
		issue(mise_pkg::OP_HALT, 8'h00, 3'h0, 8'h00, 12'h000);
		idle(4);
		chk({powerdown_mode, instr_ready}, 16'h0002); // sleeping
		wake_up = 1'b1;
		@(negedge sys_clk);
		wake_up = 1'b0;
		watchdog_timeout = 1'b1;
		@(negedge sys_clk);
		watchdog_timeout = 1'b0;
		e_to = 1'b1;
		chk(powerdown_mode, 16'h0000); // woken
		issue(mise_pkg::OP_PRECLEAR_FIRST, 8'h00, 3'h0, 8'h00, 12'h000);
		issue(mise_pkg::OP_NOP, 8'h00, 3'h0, 8'h00, 12'h000);
		issue(mise_pkg::OP_PRECLEAR_SECOND, 8'h00, 3'h0, 8'h00, 12'h000);
		issue(mise_pkg::OP_PRECLEAR_FIRST, 8'h00, 3'h0, 8'h00, 12'h000);
		idle(1);
		watchdog_timeout = 1'b1;
		@(negedge sys_clk);
		watchdog_timeout = 1'b0;
		e_to = 1'b1;
		issue(mise_pkg::OP_WATCHDOG_CLEAR, 8'h00, 3'h0, 8'h00, 12'h000);
		idle(3);
		chk(16'(wq.size()), 16'h0000); // all writes seen
		$display("test watchdog done");
		complete_run();
	end
endmodule
